/* fsm_far_model.sv */
/* Far side of the sequence mover: a memory target that answers every
   request with a one-cycle done pulse, and the downstream local bus
   neighbour. Assumes one clock and one 32-bit word per memory request. */
`timescale 1ns/1ns
module fsm_far_model (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic [3:0]  lat,
   input  wire logic        stall,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output logic             mem_done,
   output logic [31:0]      mem_rdata,
   output logic             lb_ready
);
   logic [31:0] store [logic [31:0]];
   logic [3:0]  wait_r;
   logic [7:0]  tick_r;
   // ==================================================
   // Memory target and neighbour ready
   // Read data flips on every edge that loads no read word, so a stale word never looks valid
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mem_done  <= 1'b0;
         mem_rdata <= 32'h0;
         wait_r    <= 4'h0;
         tick_r    <= 8'h00;
         lb_ready  <= 1'b0;
      end else begin
         tick_r    <= tick_r + 8'h01;
         lb_ready  <= !stall || (tick_r[0] ^ tick_r[2]);
         mem_done  <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_done) begin
            if (wait_r == lat) begin
               wait_r   <= 4'h0;
               mem_done <= 1'b1;
               if (mem_we) store[mem_addr] = mem_wdata;
               else mem_rdata <= store.exists(mem_addr) ? store[mem_addr] : {mem_addr[15:0], ~mem_addr[15:0]};
            end else begin
               wait_r <= wait_r + 4'h1;
            end
         end
      end
   end
endmodule

/* fsm_mover.sv */
/*
 * Sequence operation engine: fetches four-field operation words and moves
 * data between the link stream, the local bus and VXI / shared RAM memory.
 * Assumes the link streams and memory port are synchronous to CLK_SYS and
 * that software supplies operation words in legal form.
 */
`timescale 1ns/1ns
module fsm_mover
   import fsm_pkg::*;
#(
   parameter int DW = 32
) (
   input  wire logic        CLK_SYS,
   input  wire logic        RST_B,
   // Operation word port
   input  wire logic        OP_VALID,
   output logic             OP_READY,
   input  wire logic [15:0] OP_CODE,
   input  wire logic [31:0] OP_COUNT,
   input  wire logic [31:0] OP_ADDR,
   input  wire logic [31:0] OP_AUX,
   input  wire logic        RX_SEQ,
   output logic             OP_ERR,
   // Link receive stream (one 32-bit word a beat)
   input  wire logic        RX_VALID,
   output logic             RX_READY,
   input  wire logic [31:0] RX_DATA,
   // Link transmit stream
   output logic             TX_VALID,
   input  wire logic        TX_READY,
   output logic [31:0]      TX_DATA,
   // Local bus downstream
   output logic             LB_VALID,
   input  wire logic        LB_READY,
   output logic [31:0]      LB_DATA,
   output logic             LB_BLK_END,
   output logic             LB_FRM_END,
   output logic [7:0]       LB_WID,
   input  wire logic        LB_PASS_END,
   // Local bus upstream
   input  wire logic        LBI_VALID,
   output logic             LBI_READY,
   input  wire logic [31:0] LBI_DATA,
   // Memory port (single word, done pulse)
   output logic             MEM_REQ,
   output logic             MEM_WE,
   output logic [1:0]       MEM_SPACE,
   output logic [1:0]       MEM_ACC,
   output logic [31:0]      MEM_ADDR,
   output logic [31:0]      MEM_WDATA,
   input  wire logic        MEM_DONE,
   input  wire logic [31:0] MEM_RDATA
);
   if (DW != 32) begin : g_dw_chk
      $error("fsm_mover supports DW of 32 only");
   end

   typedef enum logic [3:0] {S_IDLE, S_WAITPASS, S_LBOUT, S_MRD, S_TXW, S_RXW, S_MWR,
                             S_PAD, S_DROP, S_FLAGRD, S_MONCPY, S_FLAGWR, S_SRC} fsm_st_t;

   // =====================================================
   // State
   fsm_st_t     st_r, st_nxt;
   logic [31:0] left_r, left_nxt;      // Bytes left in operation
   logic [23:0] blk_left_r, blk_left_nxt;
   logic [23:0] bpb_r, bpb_nxt;
   logic [31:0] addr_r, addr_nxt;
   logic [31:0] mon_r, mon_nxt;       // Monitor write pointer
   logic [31:0] word_r, word_nxt;
   logic        fifo_r, fifo_nxt;
   logic        mon_en_r, mon_en_nxt;
   logic        mon_on_r, mon_on_nxt;  // Flag was zero, copy active
   logic        lbsrc_r, lbsrc_nxt;    // Source is upstream local bus
   logic [1:0]  sp_r, sp_nxt;
   logic [1:0]  acc_r, acc_nxt;
   logic [1:0]  msp_r, msp_nxt;
   logic [7:0]  wid_r, wid_nxt;
   logic        err_r, err_nxt;
   logic        blk_end_c, frm_end_c;
   logic        LB_VALID_r;
   logic [31:0] lb_data_r;
   logic [31:0] mon_base_r;
   logic [31:0] mon_nxt_base;

   // Operation class decode
   logic is_lb, is_rd, is_rdmon, is_wr, is_lbmon;
   assign is_lb    = (OP_CODE == OP_LB_GEN) || (OP_CODE == OP_LB_APPEND);
   assign is_rd    = (OP_CODE >= OP_RD_LO) && (OP_CODE <= OP_RD_HI);
   assign is_rdmon = (OP_CODE >= OP_RDMON_LO) && (OP_CODE <= OP_RDMON_HI);
   assign is_wr    = (OP_CODE >= OP_WR_LO) && (OP_CODE <= OP_WR_HI);
   assign is_lbmon = (OP_CODE >= OP_LBMON_LO) && (OP_CODE <= OP_LBMON_HI);

   logic lb_ok;  // Local bus receive parameters legal
   assign lb_ok = RX_SEQ && (OP_COUNT >= BLK_CNT_MIN) && (OP_COUNT <= BLK_CNT_MAX)
                  && (OP_AUX[BPB_MSB:BPB_LSB] >= BPB_MIN) && (OP_AUX[BPB_MSB:BPB_LSB] <= BPB_MAX)
                  && (OP_AUX[1:0] == 2'b00) && (OP_AUX[WID_MSB:WID_LSB] <= 8'h03);

   logic last_word;
   assign last_word = (left_r <= 32'h00000004);
   assign OP_READY  = (st_r == S_IDLE);
   assign blk_end_c = (blk_left_r <= 24'h000004);
   assign frm_end_c = blk_end_c && last_word;

   // Handshake outputs follow the state directly; RX_READY in S_LBOUT also needs local bus room (no word held or LB_READY)
   assign RX_READY  = (st_r == S_RXW) || (st_r == S_DROP) || (st_r == S_LBOUT && (!LB_VALID_r || LB_READY));
   assign LBI_READY = (st_r == S_SRC) && lbsrc_r;
   assign TX_VALID  = (st_r == S_TXW) || (st_r == S_PAD);
   assign MEM_REQ   = (st_r == S_MRD) || (st_r == S_MWR) || (st_r == S_FLAGRD)
                      || (st_r == S_MONCPY) || (st_r == S_FLAGWR);
   assign MEM_WE    = (st_r == S_MWR) || (st_r == S_MONCPY) || (st_r == S_FLAGWR);

   assign LB_VALID = LB_VALID_r;
   assign LB_DATA  = lb_data_r;
   assign LB_WID   = wid_r;
   assign OP_ERR   = err_r;
   assign TX_DATA  = (st_r == S_PAD) ? 32'h00000000 : word_r;

   // Memory address/space selection depends on copy phase
   always_comb begin
      MEM_SPACE = sp_r;
      MEM_ACC   = acc_r;
      MEM_ADDR  = addr_r;
      MEM_WDATA = word_r;
      if (st_r == S_FLAGRD || st_r == S_MONCPY || st_r == S_FLAGWR) begin
         MEM_SPACE = msp_r;
         MEM_ACC   = AK_D16X2;
         MEM_ADDR  = (st_r == S_MONCPY) ? mon_r : mon_nxt_base;
         MEM_WDATA = (st_r == S_FLAGWR) ? FLAG_FULL : word_r;
      end
   end
   assign mon_nxt_base = mon_base_r;

   // Local bus output staging
   logic        lbv_nxt;
   logic [31:0] lbd_nxt;
   logic        lbb_nxt, lbf_nxt, lbb_r, lbf_r;
   assign LB_BLK_END = lbb_r;
   assign LB_FRM_END = lbf_r;

   // =====================================================
   // Sequencer next state
   always_comb begin
      st_nxt = st_r; left_nxt = left_r; blk_left_nxt = blk_left_r; bpb_nxt = bpb_r;
      addr_nxt = addr_r; mon_nxt = mon_r; word_nxt = word_r; fifo_nxt = fifo_r;
      mon_en_nxt = mon_en_r; mon_on_nxt = mon_on_r; lbsrc_nxt = lbsrc_r;
      sp_nxt = sp_r; acc_nxt = acc_r; msp_nxt = msp_r; wid_nxt = wid_r; err_nxt = 1'b0;
      lbv_nxt = LB_VALID_r; lbd_nxt = lb_data_r; lbb_nxt = lbb_r; lbf_nxt = lbf_r;
      if (LB_VALID_r && LB_READY) begin
         lbv_nxt = 1'b0;
         lbb_nxt = 1'b0;
         lbf_nxt = 1'b0;
      end
      case (st_r)
         S_IDLE: begin
            if (OP_VALID) begin
               left_nxt = OP_COUNT;
               addr_nxt = OP_ADDR;
               mon_en_nxt = 1'b0;
               lbsrc_nxt = 1'b0;
               // low code bits pick space, access and FIFO variant
               sp_nxt = OP_CODE[1:0];
               acc_nxt = (OP_CODE[1:0] == SP_SRAM) ? AK_D16 : OP_CODE[3:2]; // shared RAM D16
               fifo_nxt = OP_CODE[4] && (OP_CODE[1:0] != SP_SRAM);
               msp_nxt = OP_CODE[8] ? SP_A24 : SP_SRAM;
               if (is_lb) begin
                  if (lb_ok) begin
                     bpb_nxt = OP_AUX[BPB_MSB:BPB_LSB];
                     blk_left_nxt = OP_AUX[BPB_MSB:BPB_LSB];
                     wid_nxt = OP_AUX[WID_MSB:WID_LSB];
                     left_nxt = OP_COUNT * {8'h00, OP_AUX[BPB_MSB:BPB_LSB]};
                     // append waits for passing frame to end
                     st_nxt = (OP_CODE == OP_LB_APPEND) ? S_WAITPASS : S_LBOUT;
                  end else begin
                     err_nxt = 1'b1; // refused outside receive sequences or with illegal count, block size or width
                  end
               end else if (is_rd || is_rdmon) begin
                  mon_en_nxt = is_rdmon;
                  mon_nxt = OP_AUX + MON_HDR_BYTES;
                  st_nxt = is_rdmon ? S_FLAGRD : S_MRD;
               end else if (is_wr) begin
                  st_nxt = S_RXW;
               end else if (OP_CODE == OP_PAD) begin
                  st_nxt = (OP_COUNT == 32'h0) ? S_IDLE : S_PAD;
               end else if (OP_CODE == OP_DROP) begin
                  st_nxt = S_DROP;
               end else if (is_lbmon) begin
                  // local bus source with monitor copy
                  lbsrc_nxt = 1'b1;
                  mon_en_nxt = 1'b1;
                  msp_nxt = OP_CODE[0] ? SP_A24 : SP_SRAM;
                  left_nxt = OP_COUNT * {8'h00, OP_AUX[BPB_MSB:BPB_LSB]};
                  mon_nxt = OP_ADDR + MON_HDR_BYTES;
                  st_nxt = S_FLAGRD;
               end else begin
                  err_nxt = 1'b1;
               end
            end
         end
         S_WAITPASS: if (LB_PASS_END) st_nxt = S_LBOUT;
         S_LBOUT: begin
            if (!lbv_nxt && RX_VALID) begin
               lbv_nxt = 1'b1;
               lbd_nxt = RX_DATA;
               lbb_nxt = blk_end_c;
               lbf_nxt = frm_end_c;
               blk_left_nxt = blk_end_c ? bpb_r : blk_left_r - 24'h000004;
               left_nxt = left_r - 32'h00000004;
               if (last_word) st_nxt = S_IDLE;
            end
         end
         // flag read: zero enables the copy
         S_FLAGRD: if (MEM_DONE) begin
            mon_on_nxt = (MEM_RDATA == 32'h0);
            st_nxt = lbsrc_r ? S_SRC : S_MRD;
         end
         S_SRC: if (LBI_VALID) begin
            word_nxt = LBI_DATA;
            st_nxt = S_TXW;
         end
         S_MRD: if (MEM_DONE) begin
            word_nxt = MEM_RDATA;
            st_nxt = S_TXW;
         end
         S_TXW: if (TX_READY) begin
            left_nxt = left_r - 32'h00000004;
            if (!fifo_r) addr_nxt = addr_r + 32'h00000004;
            if (mon_en_r && mon_on_r) st_nxt = S_MONCPY;
            else if (last_word) st_nxt = S_IDLE;
            else st_nxt = lbsrc_r ? S_SRC : S_MRD;
         end
         S_MONCPY: if (MEM_DONE) begin
            mon_nxt = mon_r + 32'h00000004;
            st_nxt = (left_r == 32'h00000000) ? S_FLAGWR : (lbsrc_r ? S_SRC : S_MRD); // Count already taken
         end
         S_FLAGWR: if (MEM_DONE) st_nxt = S_IDLE;
         S_RXW: if (RX_VALID) begin
            word_nxt = RX_DATA;
            st_nxt = S_MWR;
         end
         S_MWR: if (MEM_DONE) begin
            left_nxt = left_r - 32'h00000004;
            if (!fifo_r) addr_nxt = addr_r + 32'h00000004;
            st_nxt = last_word ? S_IDLE : S_RXW;
         end
         S_PAD: if (TX_READY) begin
            left_nxt = left_r - 32'h00000004;
            if (last_word) st_nxt = S_IDLE;
         end
         S_DROP: if (RX_VALID) begin
            left_nxt = left_r - 32'h00000004;
            if (last_word) st_nxt = S_IDLE;
         end
         default: st_nxt = S_IDLE;
      endcase
   end

   logic [31:0] mon_base_nxt;
   assign mon_base_nxt = (st_r == S_IDLE && OP_VALID) ? (is_lbmon ? OP_ADDR : OP_AUX) : mon_base_r;

   // =====================================================
   // Registers
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         st_r <= S_IDLE; left_r <= 32'h0; blk_left_r <= 24'h0; bpb_r <= 24'h0;
         addr_r <= 32'h0; mon_r <= 32'h0; word_r <= 32'h0; fifo_r <= 1'b0;
         mon_en_r <= 1'b0; mon_on_r <= 1'b0; lbsrc_r <= 1'b0; sp_r <= 2'h0;
         acc_r <= 2'h0; msp_r <= 2'h0; wid_r <= LB_WID_RST; err_r <= 1'b0;
         LB_VALID_r <= 1'b0; lb_data_r <= 32'h0; lbb_r <= 1'b0; lbf_r <= 1'b0;
         mon_base_r <= 32'h0;
      end else begin
         st_r <= st_nxt; left_r <= left_nxt; blk_left_r <= blk_left_nxt; bpb_r <= bpb_nxt;
         addr_r <= addr_nxt; mon_r <= mon_nxt; word_r <= word_nxt; fifo_r <= fifo_nxt;
         mon_en_r <= mon_en_nxt; mon_on_r <= mon_on_nxt; lbsrc_r <= lbsrc_nxt; sp_r <= sp_nxt;
         acc_r <= acc_nxt; msp_r <= msp_nxt; wid_r <= wid_nxt; err_r <= err_nxt;
         LB_VALID_r <= lbv_nxt; lb_data_r <= lbd_nxt; lbb_r <= lbb_nxt; lbf_r <= lbf_nxt;
         mon_base_r <= mon_base_nxt;
      end
   end

   // =====================================================
   // Checks
   property p_frm_blk;
      @(posedge CLK_SYS) disable iff (!RST_B) LB_FRM_END |-> LB_BLK_END;
   endproperty
   a_frm_blk: assert property (p_frm_blk) else $error("frame marker without block marker");
   property p_one_op;
      @(posedge CLK_SYS) disable iff (!RST_B) (st_r inside {S_TXW, S_MWR} && !last_word) |=> st_r != S_IDLE;
   endproperty
   a_one_op: assert property (p_one_op) else $error("operation ended before its last word");
   property p_pad_zero;
      @(posedge CLK_SYS) disable iff (!RST_B) (st_r == S_PAD) |-> (TX_DATA == 32'h0) && TX_VALID;
   endproperty
   a_pad_zero: assert property (p_pad_zero) else $error("padding not zero");
   property p_lb_rxseq;
      @(posedge CLK_SYS) disable iff (!RST_B) (OP_VALID && OP_READY && is_lb && !RX_SEQ) |=> err_r;
   endproperty
   a_lb_rxseq: assert property (p_lb_rxseq) else $error("local bus op outside receive");
   property p_fifo_addr;
      @(posedge CLK_SYS) disable iff (!RST_B) (fifo_r && st_r == S_MWR && MEM_DONE) |=> $stable(addr_r);
   endproperty
   a_fifo_addr: assert property (p_fifo_addr) else $error("fifo address moved");
   property p_sram_d16;
      @(posedge CLK_SYS) disable iff (!RST_B) (MEM_REQ && MEM_SPACE == SP_SRAM) |-> MEM_ACC != AK_D32;
   endproperty
   a_sram_d16: assert property (p_sram_d16) else $error("shared RAM not D16");
   property p_drop_ready;
      @(posedge CLK_SYS) disable iff (!RST_B) (st_r == S_DROP) |-> RX_READY && !TX_VALID;
   endproperty
   a_drop_ready: assert property (p_drop_ready) else $error("drop not consuming");
   property p_flag_set;
      @(posedge CLK_SYS) disable iff (!RST_B) (st_r == S_FLAGWR) |-> MEM_WE && MEM_WDATA == FLAG_FULL;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set to one");
endmodule

/* fsm_pkg.sv */
/*
 * Constants for the sequence mover: operation codes, field layouts,
 * access modes, reset values and limits.
 * Assumes a single clock domain; users import fsm_pkg::*.
 */
package fsm_pkg;
   // =====================================================
   // Operation codes and ranges
   localparam logic [15:0] OP_LB_GEN      = 16'h2000;
   localparam logic [15:0] OP_LB_APPEND   = 16'h2001;
   localparam logic [15:0] OP_RD_LO       = 16'h3000;
   localparam logic [15:0] OP_RD_HI       = 16'h3012;
   localparam logic [15:0] OP_PAD         = 16'h3100;
   localparam logic [15:0] OP_RDMON_LO    = 16'h3812;
   localparam logic [15:0] OP_RDMON_HI    = 16'h3A05;
   localparam logic [15:0] OP_WR_LO       = 16'h4000;
   localparam logic [15:0] OP_WR_HI       = 16'h4012;
   localparam logic [15:0] OP_DROP        = 16'h4100;
   localparam logic [15:0] OP_LBMON_LO    = 16'h5000;
   localparam logic [15:0] OP_LBMON_HI    = 16'h5015;
   // =====================================================
   // Auxiliary word fields
   localparam int          BPB_LSB        = 0;
   localparam int          BPB_MSB        = 23;
   localparam int          WID_LSB        = 24;
   localparam int          WID_MSB        = 31;
   localparam logic [23:0] BPB_MIN        = 24'h000010;
   localparam logic [23:0] BPB_MAX        = 24'h00FFFC;
   localparam logic [31:0] BLK_CNT_MIN    = 32'h00000001;
   localparam logic [31:0] BLK_CNT_MAX    = 32'h00000100;
   localparam logic [31:0] SRAM_OFS_MAX   = 32'h00040000;
   localparam logic [31:0] MON_HDR_BYTES  = 32'h00000004;
   localparam logic [31:0] FLAG_FULL      = 32'h00000001;
   // =====================================================
   // Memory spaces and access kinds (low bits of the operation code)
   typedef enum logic [1:0] {SP_A16, SP_A24, SP_A32, SP_SRAM} fsm_space_t;
   typedef enum logic [1:0] {AK_D16, AK_D16X2, AK_D32} fsm_acc_t;
   localparam logic [7:0]  LB_WID_RST     = 8'h00;
endpackage

/* test_fibre_vxi_sequence_mover.sv */
/* Testbench for the sequence mover: issues operation words, feeds the
   link receive stream, sinks transmit words and checks every output word
   in order against notes queued by the driver. Assumes fsm_far_model. */
`timescale 1ns/1ns
module test_fibre_vxi_sequence_mover;
   import fsm_pkg::*;
   logic        CLK_SYS = 1'b0, RST_B = 1'b0, OP_VALID = 1'b0, RX_SEQ = 1'b0, RX_VALID = 1'b0;
   logic        TX_READY = 1'b0, LB_PASS_END = 1'b0, slow = 1'b0, LBI_VALID = 1'b0;
   logic [15:0] OP_CODE = 16'h0000;
   logic [31:0] OP_COUNT = 32'h0, OP_ADDR = 32'h0, OP_AUX = 32'h0, RX_DATA = 32'h0, LBI_DATA = 32'h0, d, a;
   logic [3:0]  lat = 4'h0;
   logic        OP_READY, OP_ERR, RX_READY, TX_VALID, LB_VALID, LB_READY, LB_BLK_END, LB_FRM_END;
   logic        LBI_READY, MEM_REQ, MEM_WE, MEM_DONE;
   logic [1:0]  MEM_SPACE, MEM_ACC;
   logic [7:0]  LB_WID, lfsr_r = 8'h28;
   logic [31:0] TX_DATA, LB_DATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, rx_q[$], tx_q[$], lbi_q[$];
   logic [33:0] lb_q[$];
   logic [68:0] mem_q[$];
   logic [31:0] bad_cnt [7] = '{32'h1, 32'h0, 32'h101, 32'h1, 32'h1, 32'h1, 32'h1};
   logic [31:0] bad_aux [7] = '{32'h03000010, 32'h03000010, 32'h03000010, 32'h03000012,
                                32'h0300000C, 32'h04000010, 32'h03000010};
   int          num_errors = 0, checks_done = 0, err_seen = 0, cycles = 0, e, n;
   string       test_name = "reset";

   fsm_mover #(.DW(32)) uut (
      .CLK_SYS(CLK_SYS), .RST_B(RST_B), .OP_VALID(OP_VALID), .OP_READY(OP_READY), .OP_CODE(OP_CODE),
      .OP_COUNT(OP_COUNT), .OP_ADDR(OP_ADDR), .OP_AUX(OP_AUX), .RX_SEQ(RX_SEQ), .OP_ERR(OP_ERR),
      .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_DATA(RX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
      .TX_DATA(TX_DATA), .LB_VALID(LB_VALID), .LB_READY(LB_READY), .LB_DATA(LB_DATA), .LB_BLK_END(LB_BLK_END),
      .LB_FRM_END(LB_FRM_END), .LB_WID(LB_WID), .LB_PASS_END(LB_PASS_END), .LBI_VALID(LBI_VALID),
      .LBI_READY(LBI_READY), .LBI_DATA(LBI_DATA), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_SPACE(MEM_SPACE),
      .MEM_ACC(MEM_ACC), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_DONE(MEM_DONE), .MEM_RDATA(MEM_RDATA));
   fsm_far_model far (.clk_sys(CLK_SYS), .rst_b(RST_B), .lat(lat), .stall(slow), .mem_req(MEM_REQ),
      .mem_we(MEM_WE), .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA), .mem_done(MEM_DONE),
      .mem_rdata(MEM_RDATA), .lb_ready(LB_READY));

   always #2 CLK_SYS = ~CLK_SYS;

   // ==================================================
   // Helpers
   function automatic logic [31:0] rnd();
      logic [31:0] v;
      v = 32'h0;
      repeat (4) begin
         lfsr_r = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
         v = {v[23:0], lfsr_r};
      end
      return v;
   endfunction
   task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t in %s: saw %h, expected %h", $time, test_name, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("Totals: %0d comparisons, %0d mismatches", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic next_test(input string s);
      $display("Test %s finished", test_name);
      test_name = s;
      @(negedge CLK_SYS);
   endtask
   // Issue one word, then wait until idle with every note consumed
   task automatic do_op(input logic [15:0] c, input logic [31:0] cnt, input logic [31:0] adr,
                        input logic [31:0] aux, input logic busy);
      int k;
      @(posedge CLK_SYS);
      OP_VALID <= 1'b1;
      OP_CODE  <= c;
      OP_COUNT <= cnt;
      OP_ADDR  <= adr;
      OP_AUX   <= aux;
      // Ready is looked at where it is settled, the word is taken at the next edge
      k = 0;
      do begin
         @(negedge CLK_SYS);
         k++;
      end while (OP_READY !== 1'b1 && k < 50);
      @(posedge CLK_SYS);
      OP_VALID <= 1'b0;
      if (busy) begin
         @(negedge CLK_SYS);
         chk(OP_READY, 1'b0);
      end
      k = 0;
      while ((OP_READY !== 1'b1 || rx_q.size() || tx_q.size() || lb_q.size() || mem_q.size() || lbi_q.size())
             && k < 20000) begin
         @(negedge CLK_SYS);
         k++;
      end
      chk({OP_READY, rx_q.size() + tx_q.size() + lb_q.size() + mem_q.size() + lbi_q.size()}, {1'b1, 32'h0});
   endtask

   // ==================================================
   // Stream source, sink and output monitor
   // Idle receive data is inverted so stale words never pass as valid
   always @(posedge CLK_SYS) begin
      if (RST_B) begin
         cycles++;
         if (OP_ERR === 1'b1) err_seen++;
         if (RX_VALID && RX_READY) void'(rx_q.pop_front());
         if (!RX_VALID || RX_READY) begin
            RX_VALID <= (rx_q.size() > 0) && (!slow || rnd() % 2 == 1);
            RX_DATA  <= (rx_q.size() > 0) ? rx_q[0] : ~RX_DATA;
         end
         if (LBI_VALID && LBI_READY) void'(lbi_q.pop_front());
         if (!LBI_VALID || LBI_READY) begin
            LBI_VALID <= (lbi_q.size() > 0);
            LBI_DATA  <= (lbi_q.size() > 0) ? lbi_q[0] : ~LBI_DATA;
         end
         TX_READY <= !slow || rnd() % 3 != 0;
         if (TX_VALID && TX_READY) chk({1'b1, TX_DATA}, tx_q.size() ? {1'b1, tx_q.pop_front()} : 33'h0);
         if (LB_VALID && LB_READY) chk({1'b1, LB_DATA, LB_BLK_END, LB_FRM_END},
            lb_q.size() ? {1'b1, lb_q.pop_front()} : 35'h0);
         if (MEM_REQ && MEM_DONE) chk({1'b1, MEM_WE, MEM_SPACE, MEM_ACC, MEM_ADDR, MEM_WE ? MEM_WDATA : 32'h0},
            mem_q.size() ? {1'b1, mem_q.pop_front()} : 70'h0);
         if (cycles == 60000) begin
            chk(1'b0, 1'b1);
            close_out();
         end
      end
   end

   // ==================================================
   // Main sequence
   initial begin
      repeat (5) @(posedge CLK_SYS);
      #1 chk({OP_READY, OP_ERR, RX_READY, TX_VALID, LB_VALID, MEM_REQ, LB_WID}, {6'b100000, LB_WID_RST});
      @(posedge CLK_SYS);
      RST_B <= 1'b1;
      next_test("drop");
      slow <= 1'b1;
      rx_q.push_back(rnd());
      rx_q.push_back(rnd());
      do_op(OP_DROP, 32'h8, 32'h0, 32'h0, 1'b1);
      // zero padding, none for a zero count
      next_test("pad");
      tx_q.push_back(32'h0);
      tx_q.push_back(32'h0);
      do_op(OP_PAD, 32'h8, 32'h0, 32'h0, 1'b1);
      do_op(OP_PAD, 32'h0, 32'h0, 32'h0, 1'b0);
      // buffer steps, FIFO stays; slow then prompt memory
      next_test("memory");
      for (int f = 0; f < 2; f++) begin
         lat <= (f == 0) ? 4'h5 : 4'h0;
         for (int i = 0; i < 2; i++) begin
            a = (f == 0) ? 32'h1000 + 4 * i : 32'h2000;
            d = rnd();
            rx_q.push_back(d);
            mem_q.push_back({1'b1, 2'd2, (f == 0) ? 2'd2 : 2'd0, a, d});
         end
         do_op((f == 0) ? 16'h400A : OP_WR_HI, 32'h8, (f == 0) ? 32'h1000 : 32'h2000, 32'h0, 1'b1);
         for (int i = 0; i < 2; i++) begin
            a = (f == 0) ? 32'h300 + 4 * i : 32'h300;
            mem_q.push_back({1'b0, 2'd2, (f == 0) ? 2'd2 : 2'd0, a, 32'h0});
            tx_q.push_back({a[15:0], ~a[15:0]});
         end
         do_op((f == 0) ? 16'h300A : OP_RD_HI, 32'h8, 32'h300, 32'h0, 1'b1);
      end
      // four-word blocks, every width code, 256 blocks
      next_test("local bus");
      RX_SEQ <= 1'b1;
      for (int w = 0; w < 4; w++) begin
         n = (w == 3) ? 256 : 1;
         for (int i = 0; i < 4 * n; i++) begin
            d = rnd();
            rx_q.push_back(d);
            lb_q.push_back({d, i % 4 == 3, i == 4 * n - 1});
         end
         LB_PASS_END <= (w == 1);
         do_op((w == 1) ? OP_LB_APPEND : OP_LB_GEN, n, 32'h0, {w[7:0], 24'h000010}, 1'b1);
         chk(LB_WID, w[7:0]);
      end
      // zeroed flag lets one copy through, then the full flag skips it
      next_test("monitor");
      for (int m = 0; m < 2; m++) begin
         a = m ? 32'h9000 : 32'h8000;
         rx_q.push_back(32'h0);
         mem_q.push_back({1'b1, 2'd1, 2'd0, a, 32'h0});
         do_op(16'h4001, 32'h4, a, 32'h0, 1'b1);
         for (int r = 0; r < 2; r++) begin
            mem_q.push_back({1'b0, 2'd1, 2'd1, a, 32'h0});
            for (int i = 0; i < 4; i++) begin
               n = 32'h500 + 4 * i;
               d = m ? rnd() : {n[15:0], ~n[15:0]};
               if (m) lbi_q.push_back(d);
               else mem_q.push_back({1'b0, 2'd0, 2'd0, n, 32'h0});
               tx_q.push_back(d);
               if (r == 0) mem_q.push_back({1'b1, 2'd1, 2'd1, a + 32'h4 + 32'h4 * i, d});
            end
            if (r == 0) mem_q.push_back({1'b1, 2'd1, 2'd1, a, 32'h1});
            do_op(m ? 16'h5001 : 16'h3900, m ? 32'h1 : 32'h10, m ? 32'h9000 : 32'h500,
                  m ? 32'h03000010 : 32'h8000, 1'b1);
         end
      end
      // refused words raise one error pulse
      next_test("refusals");
      chk(err_seen, 0);
      for (int i = 0; i < 7; i++) begin
         e = err_seen;
         RX_SEQ <= (i != 0);
         do_op((i == 6) ? 16'h7777 : OP_LB_GEN, bad_cnt[i], 32'h0, bad_aux[i], 1'b0);
         repeat (2) @(negedge CLK_SYS);
         chk(err_seen, e + 1);
      end
      next_test("end");
      close_out();
   end
endmodule
